// ===== inc/sacc_map.svh
// field positions, write mask, reset values and timing counts of the converter control
// assumes a 10 MHz main clock; included by the design and the bench
`ifndef SACC_MAP_SVH
`define SACC_MAP_SVH
`define SACC_MODE_RST 8'h00
`define SACC_SUB_RST 8'h00
`define SACC_CHAN_RST 3'h0
`define SACC_RESULT_RST 8'h00
`define SACC_RUN_BIT 7
`define SACC_REF_BIT 0
`define SACC_FR_LSB 3
`define SACC_FR_MSB 5
`define SACC_SUBSEL_BIT 7
`define SACC_MODE_WMASK 8'hB9
`define SACC_CLK_PERIOD_NS 100
`define SACC_REF_SETTLE_NS 14000
`define SACC_REF_SETTLE_CYC ((`SACC_REF_SETTLE_NS + `SACC_CLK_PERIOD_NS - 1) / `SACC_CLK_PERIOD_NS)
`define SACC_FR_144 3'h0
`define SACC_FR_120 3'h1
`define SACC_FR_96 3'h2
`define SACC_FR_72 3'h4
`define SACC_STEP_144 8'h10
`define SACC_STEP_120 8'h0D
`define SACC_STEP_96 8'h0A
`define SACC_STEP_72 8'h08
`define SACC_SAMP_LONG 8'h10
`define SACC_SAMP_SHORT 8'h08
`define SACC_TRIAL_MSB 8'h80
`endif

// ===== inc/sacc_pkg.sv
// types shared by the converter control and its bench
// the numbers live in sacc_map.svh
package sacc_pkg;
    typedef enum logic [1:0] {SACC_IDLE, SACC_SAMPLE, SACC_CONVERT} sacc_phase_t;

    typedef struct packed {
        logic mode_we;
        logic sub_we;
        logic chan_we;
        logic [7:0] data;
    } sacc_wr_t;

    typedef struct packed {
        sacc_phase_t phase;
        logic [7:0] mode;
        logic sub_sel;
        logic [2:0] chan;
        logic [7:0] cnt;
        logic [2:0] bit_idx;
        logic [7:0] sar;
        logic [7:0] result;
        logic [7:0] rd_data;
        logic irq;
        logic flag;
        logic cmp_s1;
        logic cmp_s2;
        logic cmp_s3;
        logic cmp;
        logic [7:0] ref_cnt;
        logic ref_ok;
        logic first_pending;
        logic suspect;
        logic sample;
        logic busy;
    } sacc_state_t;
endpackage : sacc_pkg

// ===== src/sacc_conv_ctrl.sv
// successive-approximation conversion control, 8 channels, 8-bit result
// assumes an external comparator driving cmp_i and a ladder driven by trial_code_o
// Notes on behaviour
// RULE1 - after reset, channel register picks input
// RULE2 - only a mode register write starts
// RULE3 - run bit 7 starts selected channel
// RULE4 - completion stores result and pulses interrupt
// RULE5 - converts continuously until mode rewritten
// RULE6 - run write mid-conversion restarts fresh
// RULE7 - stop write mid-conversion halts at once
// RULE8 - code is rounded ratio times 256
// RULE9 - standby stops converting
// RULE10 - read served before new result lands
// RULE11 - register write beats completion, no interrupt
// RULE12 - only first result may be unsettled
// RULE13 - software discards first unsettled result
// RULE14 - software reads while running
// RULE15 - mode write leaves done flag alone
// RULE16 - software clears done flag before restart
// RULE17 - sample phase about tenth of conversion
// RULE18 - software avoids port reads on channel
// RULE19 - bit 0 enables reference, 14 us settle
// RULE20 - time codes 144/120/96/72 or subclock
// RULE21 - channel is three-bit binary index
// RULE22 - eight bits msb first, keep if not below
// RULE23 - cycle counter times sample and bits

`timescale 1ns/1ps
`include "sacc_map.svh"

module sacc_conv_ctrl
    import sacc_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire sacc_wr_t wr_i,
    input wire logic result_rd_i,
    input wire logic flag_clr_i,
    input wire logic standby_i,
    input wire logic subclk_tick_i,
    input wire logic cmp_i,
    output logic [2:0] channel_sel_o,
    output logic sample_o,
    output logic [7:0] trial_code_o,
    output logic ref_enable_o,
    output logic busy_o,
    output logic [7:0] conv_result_o,
    output logic [7:0] rd_data_o,
    output logic conversion_done_irq_o,
    output logic conversion_done_flag_o,
    output logic result_suspect_o
);
    logic rst_s1;
    logic rst_n;
    sacc_state_t s;
    sacc_state_t next_s;
    logic [2:0] fr;
    logic legal;
    logic [7:0] step_len;
    logic [7:0] samp_len;
    logic adv;
    logic run_new;
    logic wr_any;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    assign fr = s.mode[`SACC_FR_MSB:`SACC_FR_LSB];
    assign run_new = wr_i.data[`SACC_RUN_BIT];
    assign wr_any = wr_i.mode_we | wr_i.chan_we;

    // conversion time select: step and sample lengths per code
    always_comb begin
        legal = 1'b1;
        step_len = `SACC_STEP_144;
        samp_len = `SACC_SAMP_LONG;
        if (!s.sub_sel) begin
            unique case (fr)
                `SACC_FR_144: step_len = `SACC_STEP_144; // RULE20
                `SACC_FR_120: step_len = `SACC_STEP_120; // RULE20
                `SACC_FR_96: step_len = `SACC_STEP_96; // RULE20
                `SACC_FR_72: begin
                    step_len = `SACC_STEP_72; // RULE20
                    samp_len = `SACC_SAMP_SHORT; // RULE17
                end
                default: legal = 1'b0; // RULE20
            endcase
        end
    end

    // subclock mode advances only on the multiplied subclock tick
    assign adv = !s.sub_sel || subclk_tick_i;

    always_comb begin
        next_s = s;
        next_s.irq = 1'b0;
        // comparator answer is asynchronous: taken once the last two flops agree
        next_s.cmp_s1 = cmp_i;
        next_s.cmp_s2 = s.cmp_s1;
        next_s.cmp_s3 = s.cmp_s2;
        if (s.cmp_s2 == s.cmp_s3) begin
            next_s.cmp = s.cmp_s3;
        end
        if (result_rd_i) begin
            next_s.rd_data = s.result; // RULE10
        end
        // reference settle timer; a run write before it expires marks the first result
        if (!s.mode[`SACC_REF_BIT]) begin
            next_s.ref_cnt = 8'h00;
            next_s.ref_ok = 1'b0;
        end else if (s.ref_cnt < 8'(`SACC_REF_SETTLE_CYC)) begin
            next_s.ref_cnt = s.ref_cnt + 8'h01;
        end else begin
            next_s.ref_ok = 1'b1; // RULE19
        end
        if (flag_clr_i) begin
            next_s.flag = 1'b0;
        end
        // standby parks the sequencer; a register write below still takes effect
        if (standby_i) begin
            next_s.phase = SACC_IDLE; // RULE9
        end else begin
            unique case (s.phase)
                SACC_IDLE: begin
                    if (s.mode[`SACC_RUN_BIT] && legal) begin
                        next_s.phase = SACC_SAMPLE; // RULE3
                        next_s.cnt = 8'h00;
                    end
                end
                SACC_SAMPLE: begin
                    if (adv) begin
                        if (s.cnt == samp_len - 8'h01) begin
                            next_s.phase = SACC_CONVERT; // RULE17
                            next_s.cnt = 8'h00;
                            next_s.bit_idx = 3'h7;
                            next_s.sar = `SACC_TRIAL_MSB; // RULE22
                        end else begin
                            next_s.cnt = s.cnt + 8'h01; // RULE23
                        end
                    end
                end
                SACC_CONVERT: begin
                    if (adv) begin
                        if (s.cnt == step_len - 8'h01) begin
                            next_s.cnt = 8'h00;
                            // keep the trial bit when the input is not below the level
                            next_s.sar[s.bit_idx] = s.cmp; // RULE22 RULE8
                            if (s.bit_idx == 3'h0) begin
                                next_s.phase = SACC_SAMPLE; // RULE5
                                if (!wr_any) begin // RULE11
                                    next_s.result = next_s.sar; // RULE4
                                    next_s.irq = 1'b1; // RULE4
                                    next_s.flag = 1'b1;
                                    next_s.suspect = s.first_pending; // RULE12
                                    next_s.first_pending = 1'b0;
                                end
                            end else begin
                                next_s.bit_idx = s.bit_idx - 3'h1;
                                next_s.sar[s.bit_idx - 3'h1] = 1'b1;
                            end
                        end else begin
                            next_s.cnt = s.cnt + 8'h01; // RULE23
                        end
                    end
                end
            endcase
        end
        // mode and channel register writes take precedence over a completing conversion
        if (wr_i.chan_we) begin
            next_s.chan = wr_i.data[2:0]; // RULE21
            if (s.phase != SACC_IDLE) begin
                next_s.phase = SACC_SAMPLE;
                next_s.cnt = 8'h00;
            end
        end
        if (wr_i.sub_we) begin
            next_s.sub_sel = wr_i.data[`SACC_SUBSEL_BIT];
        end
        if (wr_i.mode_we) begin
            next_s.mode = wr_i.data & `SACC_MODE_WMASK; // RULE15
            next_s.cnt = 8'h00;
            if (run_new) begin
                next_s.phase = SACC_IDLE; // RULE2 RULE6
                next_s.first_pending = !(s.ref_ok && wr_i.data[`SACC_REF_BIT]); // RULE12
            end else begin
                next_s.phase = SACC_IDLE; // RULE7
            end
        end
        // sample and busy ports are registered from the phase being entered
        next_s.sample = (next_s.phase == SACC_SAMPLE);
        next_s.busy = (next_s.phase != SACC_IDLE);
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.phase <= SACC_IDLE; // RULE1
            s.mode <= `SACC_MODE_RST;
            s.chan <= `SACC_CHAN_RST; // RULE1
            s.result <= `SACC_RESULT_RST;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    always_comb begin
        channel_sel_o = s.chan;
        // every port is a flop of the state
        sample_o = s.sample;
        trial_code_o = s.sar;
        ref_enable_o = s.mode[`SACC_REF_BIT];
        busy_o = s.busy;
        conv_result_o = s.result;
        rd_data_o = s.rd_data;
        conversion_done_irq_o = s.irq;
        conversion_done_flag_o = s.flag;
        result_suspect_o = s.suspect;
    end

    // checks
    a_stop_halts: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE7
        ce_i && wr_i.mode_we && !run_new |=> s.phase == SACC_IDLE)
        else $error("stop write did not halt");
    a_run_restarts: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE6
        ce_i && wr_i.mode_we && run_new && !standby_i
        ##1 ce_i && legal && !standby_i && !wr_i.mode_we
        |=> s.phase == SACC_SAMPLE && s.cnt == 8'h00)
        else $error("run write did not restart");
    a_irq_stores: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE4
        s.irq |-> s.result == s.sar && s.phase == SACC_SAMPLE)
        else $error("interrupt without stored result");
    a_write_wins: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE11
        ce_i && wr_any |=> !s.irq && $stable(s.result))
        else $error("completion beat a register write");
    a_read_first: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE10
        ce_i && result_rd_i |=> s.rd_data == $past(s.result))
        else $error("read did not see old result");
    a_standby_stop: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE9
        ce_i && standby_i && !wr_any |=> s.phase == SACC_IDLE)
        else $error("standby did not stop");
    a_flag_sets: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE15
        s.irq |-> s.flag)
        else $error("done flag not set");
    a_flag_kept: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE15
        ce_i && s.flag && wr_i.mode_we && !flag_clr_i |=> s.flag)
        else $error("mode write cleared flag");
    a_msb_trial: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE22
        s.phase == SACC_SAMPLE ##1 s.phase == SACC_CONVERT && !$past(wr_any)
        |-> s.sar == `SACC_TRIAL_MSB && s.bit_idx == 3'h7)
        else $error("conversion did not open at msb");
    a_illegal_idle: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE20
        s.phase == SACC_IDLE && !legal && !wr_any |=> s.phase == SACC_IDLE)
        else $error("prohibited time code converted");
    a_ref_off: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE19
        ce_i && !s.mode[`SACC_REF_BIT] |=> !s.ref_ok)
        else $error("reference ready while disabled");
    a_ref_ready: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE19
        ce_i && s.mode[`SACC_REF_BIT] && s.ref_cnt == 8'(`SACC_REF_SETTLE_CYC) |=> s.ref_ok)
        else $error("reference never settled");
    a_chan_restart: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE11
        ce_i && wr_i.chan_we && !wr_i.mode_we && s.phase != SACC_IDLE
        |=> s.phase == SACC_SAMPLE && s.cnt == 8'h00)
        else $error("channel write did not restart");
    a_chan_value: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE21
        ce_i && wr_i.chan_we |=> s.chan == $past(wr_i.data[2:0]))
        else $error("channel write not stored");
    a_sync_agree: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE22
        ce_i && s.cmp_s2 == s.cmp_s3 |=> s.cmp == $past(s.cmp_s3))
        else $error("settled comparator answer not taken");
    a_flag_clear: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE16
        ce_i && flag_clr_i |=> s.flag == s.irq)
        else $error("done flag clear mishandled");
    a_irq_pulse: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE4
        ce_i && s.irq |=> !s.irq)
        else $error("interrupt longer than one cycle");
    a_idle_waits: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE2
        s.phase == SACC_IDLE && !s.mode[`SACC_RUN_BIT] && !wr_i.mode_we |=> s.phase == SACC_IDLE)
        else $error("conversion started without run write");
    a_ce_freeze: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE23
        !ce_i |=> $stable(s))
        else $error("state moved with clock enable low");
    a_result_steady: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE4
        !s.irq |-> $stable(s.result))
        else $error("result changed without interrupt");
    a_read_keeps: assert property (@(posedge clock_i) disable iff (!rst_n) // RULE10
        ce_i && !result_rd_i |=> $stable(s.rd_data))
        else $error("read data changed without read");

    c_done: cover property (@(posedge clock_i) disable iff (!rst_n) s.irq);
    c_back_to_back: cover property (@(posedge clock_i) disable iff (!rst_n)
        s.irq ##[1:300] s.irq);
    c_abort: cover property (@(posedge clock_i) disable iff (!rst_n)
        s.phase == SACC_CONVERT && wr_i.mode_we && run_new);
    c_collide: cover property (@(posedge clock_i) disable iff (!rst_n)
        s.phase == SACC_CONVERT && s.bit_idx == 3'h0 && wr_any);
    c_standby: cover property (@(posedge clock_i) disable iff (!rst_n)
        standby_i && s.phase != SACC_IDLE);
endmodule : sacc_conv_ctrl

// ===== verif/sacc_analog_src.sv
// analog sources on the eight input pins as ideal comparator answers
// assumes levels_i holds one 8-bit code per channel, channel 0 in the low byte
`timescale 1ns/1ps
module sacc_analog_src (
    input wire logic [2:0] channel_sel_i,
    input wire logic [7:0] trial_code_i,
    input wire logic [63:0] levels_i,
    output logic cmp_o
);
    logic [7:0] level;
    assign level = levels_i[8*channel_sel_i +: 8];
    // input at or above the tap keeps the bit
    assign cmp_o = (level >= trial_code_i);
endmodule : sacc_analog_src

// ===== verif/sacc_conv_ctrl_tb_top.sv
// self-checking bench of the converter control
// assumes sacc_analog_src on the comparator side
`timescale 1ns/1ps
`include "sacc_map.svh"
module sacc_conv_ctrl_tb_top;
    import sacc_pkg::*;
    `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
        $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
    logic clock_i = 0, nrst_i = 0, rd = 0, clr = 0, stby = 0, cmp;
    logic ce = 1, tick = 0, tick_en = 0;
    sacc_wr_t wr_i = '0;
    logic [63:0] lv = 64'hFF01_A55A_807F_3C00;
    logic [2:0] ch;
    logic samp, refen, busy, irq, flag, susp;
    logic [7:0] trial, res, rdd;
    int n_fail = 0, compares = 0, n, k;
    sacc_conv_ctrl dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .wr_i(wr_i),
        .result_rd_i(rd), .flag_clr_i(clr), .standby_i(stby), .subclk_tick_i(tick),
        .cmp_i(cmp), .channel_sel_o(ch), .sample_o(samp), .trial_code_o(trial),
        .ref_enable_o(refen), .busy_o(busy), .conv_result_o(res), .rd_data_o(rdd),
        .conversion_done_irq_o(irq), .conversion_done_flag_o(flag),
        .result_suspect_o(susp));
    sacc_analog_src src (.channel_sel_i(ch), .trial_code_i(trial), .levels_i(lv),
        .cmp_o(cmp));
    initial begin
        forever #(`SACC_CLK_PERIOD_NS/2) clock_i = ~clock_i;
    end
    // subclock tick every other cycle while enabled
    always @(negedge clock_i) begin
        tick <= tick_en && !tick;
    end
    // kind bit0 mode, bit1 subclock, bit2 channel
    task automatic wr(input logic [2:0] kind, input logic [7:0] d);
        @(negedge clock_i);
        wr_i = '{kind[0], kind[1], kind[2], d};
        @(negedge clock_i);
        wr_i = '0;
    endtask : wr
    task automatic wait_irq(input int lim);
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (irq !== 1'b1 && n < lim);
    endtask : wait_irq
    task automatic t_reset;
        repeat (200) @(negedge clock_i);
        `CHK("chan", 3'h0, ch)
        `CHK("busy", 1'b0, busy)
        `CHK("result", 8'h00, res)
    endtask : t_reset
    task automatic t_codes;
        logic [2:0] cd [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        int tm [4] = '{144, 120, 96, 72};
        for (int i = 0; i < 4; i++) begin
            wr(3'h4, 8'(i));
            wr(3'h1, 8'h81 | {2'h0, cd[i], 3'h0});
            wait_irq(400);
            `CHK("chan", 3'(i), ch)
            `CHK("code", lv[8*i +: 8], res)
            wait_irq(400);
            `CHK("period", tm[i], n)
            for (k = 0; samp === 1'b1 && k < 40; k++) @(negedge clock_i);
            `CHK("sample", (i == 3) ? 8 : 16, k)
            wr(3'h1, 8'h00);
        end
        wr(3'h1, 8'h98);
        repeat (4) @(negedge clock_i);
        `CHK("bad code", 1'b0, busy)
    endtask : t_codes
    task automatic t_subclock;
        tick_en = 1'b1;
        wr(3'h2, 8'h80);
        wr(3'h1, 8'h80);
        wait_irq(400);
        wait_irq(400);
        `CHK("subclock", 288, n)
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h00);
        tick_en = 1'b0;
    endtask : t_subclock
    task automatic t_stop_restart;
        wr(3'h1, 8'h80);
        wait_irq(400);
        repeat (70) @(negedge clock_i);
        wr(3'h1, 8'h80);
        wait_irq(400);
        `CHK("restart", 1'b1, n >= 140 && n <= 150)
        repeat (60) @(negedge clock_i);
        wr(3'h1, 8'h00);
        @(negedge clock_i);
        `CHK("halt", 1'b0, busy)
        wait_irq(300);
        `CHK("no done", 300, n)
        wr(3'h1, 8'h80);
        wait_irq(400);
        stby = 1;
        repeat (2) @(negedge clock_i);
        `CHK("standby", 1'b0, busy)
        wait_irq(300);
        `CHK("standby done", 300, n)
        stby = 0;
        wait_irq(400);
        `CHK("resume", 1'b1, n < 400)
        wr(3'h1, 8'h00);
    endtask : t_stop_restart
    task automatic t_collide;
        wr(3'h4, 8'h05);
        wr(3'h1, 8'h80);
        wait_irq(400);
        lv[40 +: 8] = 8'h33;
        repeat (143) @(negedge clock_i);
        rd = 1;
        @(negedge clock_i);
        rd = 0;
        `CHK("read old", 8'hA5, rdd)
        `CHK("new result", 8'h33, res)
        clr = 1;
        @(negedge clock_i);
        clr = 0;
        lv[40 +: 8] = 8'hC6;
        repeat (141) @(negedge clock_i);
        wr(3'h4, 8'h05);
        `CHK("kept", 8'h33, res)
        `CHK("no irq", 1'b0, irq)
        `CHK("no flag", 1'b0, flag)
        wait_irq(400);
        wr(3'h1, 8'h80);
        `CHK("flag held", 1'b1, flag)
        wr(3'h1, 8'h00);
    endtask : t_collide
    task automatic t_settle;
        wr(3'h1, 8'h80);
        wait_irq(400);
        `CHK("suspect", 1'b1, susp)
        wait_irq(400);
        `CHK("second", 1'b0, susp)
        wr(3'h1, 8'h00);
        wr(3'h1, 8'h01);
        `CHK("ref", 1'b1, refen)
        repeat (`SACC_REF_SETTLE_CYC + 4) @(negedge clock_i);
        wr(3'h1, 8'h81);
        wait_irq(400);
        `CHK("settled", 1'b0, susp)
    endtask : t_settle
    task automatic t_freeze;
        wr(3'h1, 8'h80);
        wait_irq(400);
        ce = 1'b0;
        repeat (10) @(negedge clock_i);
        ce = 1'b1;
        wait_irq(400);
        `CHK("freeze", 144, n)
        wr(3'h1, 8'h00);
    endtask : t_freeze
    task automatic test_done;
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        #(`SACC_CLK_PERIOD_NS * 20000);
        n_fail++;
        test_done();
    end
    initial begin
        repeat (8) @(negedge clock_i);
        nrst_i = 1;
        repeat (4) @(negedge clock_i);
        t_reset();
        t_codes();
        t_subclock();
        t_stop_restart();
        t_collide();
        t_settle();
        t_freeze();
        test_done();
    end
endmodule : sacc_conv_ctrl_tb_top
